/* File: pot_pkg.sv */
// Shared constants, command encodings and frame carrier for the dual pot core.
// Assumes a 200 MHz system clock; the serial link clock is slower and unrelated.
package pot_pkg;

  // System clock and non-volatile store timing
  localparam int CLK_MHZ = 200;
  localparam int BUSY_MS = 20;
  localparam int BUSY_CYCLES = BUSY_MS * 1000 * CLK_MHZ; // Longest time, exact in whole cycles
  localparam int BUSY_CNT_W = 22;

  // Code widths and reset values
  localparam int CODE_W = 8;
  localparam int CNT_W = 8;
  localparam logic [7:0] NV_RESET = 8'h80;     // Non-volatile cells start at mid-scale
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Frame lengths accepted at the end of a select-low phase
  localparam logic [7:0] SHORT_LEN = 8'h08;
  localparam logic [7:0] LONG_LEN = 8'h10;

  // Serial clock rise, counted from select high, that shows the first read bit
  localparam logic [3:0] READ_FIRST_EDGE = 4'h2;
  localparam logic [3:0] READ_EDGE_SAT = 4'hF;

  // Command byte fields
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int SEL_MSB = 1;
  localparam logic [3:0] OP_WR_WIPER = 4'h0;
  localparam logic [3:0] OP_WR_NV = 4'h1;
  localparam logic [3:0] OP_CP_W2NV = 4'h2;
  localparam logic [3:0] OP_CP_NV2W = 4'h3;
  localparam logic [3:0] OP_RD_WIPER_DEF = 4'h4;
  localparam logic [3:0] OP_RD_NV_DEF = 4'h5;
  localparam logic [1:0] MID_ZERO = 2'b00;
  localparam logic [1:0] SEL_A = 2'b01;
  localparam logic [1:0] SEL_B = 2'b10;
  localparam logic [1:0] SEL_BOTH = 2'b11;

  // One decoded serial frame
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
    logic long_form;
    logic valid;
  } frame_t;

  // Channel select hits channel A (ch_b=0) or B (ch_b=1)
  function automatic logic sel_hits(input logic [1:0] sel, input logic ch_b);
    sel_hits = ch_b ? sel[1] : sel[0];
  endfunction

endpackage

/* File: bit_sync.sv */
// Two-flop level synchroniser into the system clock domain.
// Assumes the input is a slow level or a pin; reset value is given per instance.
`timescale 1ns/1ps
module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* File: link_capture.sv */
// Serial-clock domain front end: shifts in data while select is low.
// Assumes the host holds data stable around each rising serial clock edge.
`timescale 1ns/1ps
module link_capture
  import pot_pkg::*;
(
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic select_low_in,
  input wire logic sdio_in,
  output logic [15:0] hist_r,
  output logic [CNT_W-1:0] bit_cnt_r
);

  // History and running bit count; never cleared per frame because the
  // serial clock may stop, so the system side takes differences instead
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      hist_r <= 16'h0000;
      bit_cnt_r <= 8'h00;
    end else if (!select_low_in) begin
      hist_r <= {hist_r[14:0], sdio_in}; // RL19
      bit_cnt_r <= bit_cnt_r + 8'h01;
    end
  end

endmodule

/* File: dual_pot_command_exec.sv */
// Command executor of a dual 256-tap digital potentiometer: wiper and
// non-volatile registers, copies, serial read-back, store busy and mute.
// Assumes pins arrive asynchronously; serial bits are caught on sclk.
//
// Contract
// RL1: Non-volatile write is 16 bits, command then code
// RL2: Non-volatile write leaves wipers unchanged
// RL3: Non-volatile channels written singly or together
// RL4: Ready held low during every store
// RL5: Copy wiper to store, 8 or 16 bits
// RL6: Host must store before power removal
// RL7: Copy store to wiper, 8 or 16 bits
// RL8: Store loaded into wipers at power-up
// RL9: Read store: shift code out after select rises
// RL10: Read wiper: shift out, wiper unchanged
// RL11: First read bit at second clock rise
// RL12: Host keeps select high, clocks, no drive
// RL13: Select falling releases the data line
// RL14: Mute forces both wipers to zero
// RL15: Mute blocks wiper-targeting commands
// RL16: Mute never touches stored codes
// RL17: Undriven mute counts as inactive
// RL18: Opcode nibble and channel bits decoding
// RL19: Sample on rise; execute only 8/16 bits
// RL20: Codes are eight bits, zero nearest low
// RL21: Store finishes within 20 ms
// RL22: Read opcodes are parameters, same channel bits
// RL23: Store commands ignored while ready is low
`timescale 1ns/1ps
module dual_pot_command_exec
  import pot_pkg::*;
#(
  parameter int BUSY_CYCLES_P = BUSY_CYCLES,
  parameter logic [3:0] OP_RD_WIPER = OP_RD_WIPER_DEF,
  parameter logic [3:0] OP_RD_NV = OP_RD_NV_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic select_low_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic mute_in,
  output logic ready_out,
  output logic [CODE_W-1:0] wiper_a_code,
  output logic [CODE_W-1:0] wiper_b_code,
  output logic [CODE_W-1:0] nv_a_code,
  output logic [CODE_W-1:0] nv_b_code
);

  // Serial-clock side
  logic [15:0] hist;
  logic [CNT_W-1:0] bit_cnt;

  // Synchronised pins
  logic cs_s;
  logic sclk_s;
  logic mute_s;

  // Edge history on the system clock
  logic cs_d_r;
  logic sclk_d_r;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;

  // Frame bookkeeping
  logic [CNT_W-1:0] start_cnt_r;
  logic [CNT_W-1:0] frame_len;
  frame_t frame;
  logic [3:0] op;
  logic [1:0] sel;
  logic sel_ok;

  // Decoded command strobes, valid only in the select-rise cycle
  logic do_wr_wiper;
  logic do_wr_nv;
  logic do_cp_w2nv;
  logic do_cp_nv2w;
  logic do_rd_wiper;
  logic do_rd_nv;

  // State
  logic [CODE_W-1:0] wiper_a_r;
  logic [CODE_W-1:0] wiper_b_r;
  logic [CODE_W-1:0] nv_a_r;
  logic [CODE_W-1:0] nv_b_r;
  logic [BUSY_CNT_W-1:0] busy_cnt_r;
  logic busy;
  logic pwr_load_r;
  logic [CODE_W-1:0] rd_shift_r;
  logic [3:0] rd_edges_r;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_ARMED,
    RD_SHIFT
  } rd_state_t;
  rd_state_t rd_state_r;

  // Serial bits are caught on the link clock itself
  link_capture u_capture (
    .sclk(sclk),
    .rst_n(rst_n),
    .select_low_in(select_low_in),
    .sdio_in(sdio_in),
    .hist_r(hist),
    .bit_cnt_r(bit_cnt)
  );

  // Select idles high so it resets high; mute resets low (pull-down intent)
  bit_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(select_low_in),
    .sync_out(cs_s)
  );

  bit_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(sclk),
    .sync_out(sclk_s)
  );

  bit_sync #(.RESET_VAL(1'b0)) u_sync_mute ( // RL17
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(mute_in),
    .sync_out(mute_s)
  );

  // Edge detection on the synchronised copies only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      cs_d_r <= cs_s;
      sclk_d_r <= sclk_s;
    end
  end

  assign cs_rise = cs_s & ~cs_d_r;
  assign cs_fall = ~cs_s & cs_d_r;
  assign sclk_rise = sclk_s & ~sclk_d_r;

  // Bit count frozen while select is high; the link count cannot move then,
  // so sampling it multi-bit is safe once select has settled high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_cnt_r <= 8'h00;
    end else if (cs_s && cs_d_r) begin
      start_cnt_r <= bit_cnt;
    end
  end

  // Frame assembly; the command byte is always the first byte shifted in
  always_comb begin
    frame_len = bit_cnt - start_cnt_r;
    frame.long_form = (frame_len == LONG_LEN);
    frame.valid = cs_rise && ((frame_len == SHORT_LEN) || (frame_len == LONG_LEN)); // RL19
    frame.cmd = frame.long_form ? hist[15:8] : hist[7:0];
    frame.data = hist[7:0];
  end

  assign op = frame.cmd[OP_MSB:OP_LSB];
  assign sel = frame.cmd[SEL_MSB:0];
  assign sel_ok = (frame.cmd[3:2] == MID_ZERO) && (sel != 2'b00); // RL18

  // Command decode; store commands dropped while a store runs
  always_comb begin
    do_wr_wiper = 1'b0;
    do_wr_nv = 1'b0;
    do_cp_w2nv = 1'b0;
    do_cp_nv2w = 1'b0;
    do_rd_wiper = 1'b0;
    do_rd_nv = 1'b0;
    if (frame.valid && sel_ok) begin
      if (op == OP_WR_WIPER) begin
        do_wr_wiper = frame.long_form && !mute_s; // RL15
      end
      if (op == OP_WR_NV) begin
        do_wr_nv = frame.long_form && !busy; // RL1 RL23
      end
      if (op == OP_CP_W2NV) begin
        do_cp_w2nv = !busy; // RL5 RL23
      end
      if (op == OP_CP_NV2W) begin
        do_cp_nv2w = !mute_s; // RL7 RL15
      end
      if (op == OP_RD_WIPER) begin
        do_rd_wiper = 1'b1; // RL22
      end
      if (op == OP_RD_NV) begin
        do_rd_nv = 1'b1; // RL22
      end
    end
  end

  // Power-up recall runs once, in the first cycle after reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_load_r <= 1'b1;
    end else begin
      pwr_load_r <= 1'b0;
    end
  end

  // Wiper registers; mute wins over every load so zero holds while it stands
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper_a_r <= WIPER_RESET;
      wiper_b_r <= WIPER_RESET;
    end else if (mute_s) begin
      wiper_a_r <= WIPER_RESET; // RL14
      wiper_b_r <= WIPER_RESET; // RL14
    end else if (pwr_load_r) begin
      wiper_a_r <= nv_a_r; // RL8
      wiper_b_r <= nv_b_r; // RL8
    end else begin
      if (do_wr_wiper && sel_hits(sel, 1'b0)) begin
        wiper_a_r <= frame.data; // RL20
      end
      if (do_wr_wiper && sel_hits(sel, 1'b1)) begin
        wiper_b_r <= frame.data; // RL20
      end
      if (do_cp_nv2w && sel_hits(sel, 1'b0)) begin
        wiper_a_r <= nv_a_r; // RL7
      end
      if (do_cp_nv2w && sel_hits(sel, 1'b1)) begin
        wiper_b_r <= nv_b_r; // RL7
      end
    end
  end

  // Non-volatile registers; no path from mute or from wiper writes. A
  // copy while muted stores the forced zero, which is the wiper's content
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_a_r <= NV_RESET;
      nv_b_r <= NV_RESET;
    end else begin
      if (do_wr_nv && sel_hits(sel, 1'b0)) begin
        nv_a_r <= frame.data; // RL3
      end
      if (do_wr_nv && sel_hits(sel, 1'b1)) begin
        nv_b_r <= frame.data; // RL3
      end
      if (do_cp_w2nv && sel_hits(sel, 1'b0)) begin
        nv_a_r <= wiper_a_r; // RL5
      end
      if (do_cp_w2nv && sel_hits(sel, 1'b1)) begin
        nv_b_r <= wiper_b_r; // RL5
      end
    end
  end

  // Store busy timer; a fixed worst-case time rather than a model of cells
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= '0;
    end else if (do_wr_nv || do_cp_w2nv) begin
      busy_cnt_r <= BUSY_CNT_W'(BUSY_CYCLES_P); // RL21
    end else if (busy_cnt_r != '0) begin
      busy_cnt_r <= busy_cnt_r - 1'b1;
    end
  end

  assign busy = (busy_cnt_r != '0);

  // Ready output, low for the whole store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_out <= 1'b1;
    end else begin
      ready_out <= !(busy_cnt_r > BUSY_CNT_W'(1) || do_wr_nv || do_cp_w2nv); // RL4
    end
  end

  // Read-back sequencer; select high and free-running clock come from the host
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_r <= RD_IDLE;
      rd_shift_r <= READ_IDLE;
      rd_edges_r <= 4'h0;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end else if (cs_fall) begin
      rd_state_r <= RD_IDLE; // RL13
      sdio_oe <= 1'b0; // RL13
      sdio_out <= 1'b0;
    end else begin
      unique case (rd_state_r)
        RD_IDLE: begin
          rd_edges_r <= 4'h0;
          if (do_rd_wiper || do_rd_nv) begin
            // Channel A unless B alone is selected
            if (sel == SEL_B) begin
              rd_shift_r <= do_rd_nv ? nv_b_r : wiper_b_r; // RL9 RL10
            end else begin
              rd_shift_r <= do_rd_nv ? nv_a_r : wiper_a_r; // RL9 RL10
            end
            rd_state_r <= RD_ARMED;
          end
        end
        RD_ARMED: begin
          if (sclk_rise) begin
            rd_edges_r <= rd_edges_r + 4'h1;
            if (rd_edges_r + 4'h1 == READ_FIRST_EDGE) begin
              sdio_oe <= 1'b1; // RL11
              sdio_out <= rd_shift_r[CODE_W-1]; // RL9
              rd_shift_r <= {rd_shift_r[CODE_W-2:0], 1'b0};
              rd_state_r <= RD_SHIFT;
            end
          end
        end
        RD_SHIFT: begin
          // After eight bits the zeros shifted in keep the line low
          if (sclk_rise) begin
            sdio_out <= rd_shift_r[CODE_W-1]; // RL10
            rd_shift_r <= {rd_shift_r[CODE_W-2:0], 1'b0};
            if (rd_edges_r != READ_EDGE_SAT) begin
              rd_edges_r <= rd_edges_r + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Position and stored-code outputs, registered straight from state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper_a_code <= WIPER_RESET;
      wiper_b_code <= WIPER_RESET;
      nv_a_code <= NV_RESET;
      nv_b_code <= NV_RESET;
    end else begin
      wiper_a_code <= wiper_a_r; // RL2
      wiper_b_code <= wiper_b_r; // RL2
      nv_a_code <= nv_a_r; // RL16
      nv_b_code <= nv_b_r; // RL16
    end
  end

endmodule

/* File: pot_checker.sv */
// Checker of the dual pot executor: mute, store busy, recall, data line drive.
// Assumes it is bound into the executor and sees only its ports.
`timescale 1ns/1ps
module pot_checker
  import pot_pkg::*;
#(
  parameter int BUSY_CYCLES_P = BUSY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic select_low_in,
  input wire logic mute_in,
  input wire logic sdio_oe,
  input wire logic ready_out,
  input wire logic [CODE_W-1:0] wiper_a_code,
  input wire logic [CODE_W-1:0] wiper_b_code,
  input wire logic [CODE_W-1:0] nv_a_code,
  input wire logic [CODE_W-1:0] nv_b_code
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int busy_cnt_r;
  logic [2:0] since_rst_r;
  // Length of the current ready low phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= ready_out ? 0 : busy_cnt_r + 1;
    end
  end
  // Cycles since reset release, saturating so it never wraps
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_rst_r <= 3'h0;
    end else if (since_rst_r != 3'h7) begin
      since_rst_r <= since_rst_r + 3'h1;
    end
  end
  sequence s_muted; mute_in [*5]; endsequence
  sequence s_busy; !ready_out [*8]; endsequence
  property p_mute_zero; s_muted |-> wiper_a_code == 8'h00 && wiper_b_code == 8'h00; endproperty
  property p_mute_nv;
    mute_in && $past(mute_in) && ready_out |-> $stable(nv_a_code) && $stable(nv_b_code);
  endproperty
  property p_busy_hold; $fell(ready_out) |-> s_busy; endproperty
  property p_busy_len;
    $rose(ready_out) |-> busy_cnt_r >= BUSY_CYCLES_P - 1 && busy_cnt_r <= BUSY_CYCLES_P + 1;
  endproperty
  // Stored codes show one cycle after ready falls, so skip two cycles
  property p_busy_nv;
    !ready_out && !$past(ready_out) && !$past(ready_out, 2) |-> $stable(nv_a_code) && $stable(nv_b_code);
  endproperty
  property p_release; $fell(select_low_in) |-> ##[0:4] !sdio_oe; endproperty
  property p_input_low; !select_low_in [*4] |-> !sdio_oe; endproperty
  property p_oe_start; $rose(sdio_oe) |-> select_low_in && $past(select_low_in, 3); endproperty
  property p_read_still; sdio_oe && $past(sdio_oe) |-> $stable(wiper_a_code) && $stable(wiper_b_code); endproperty
  property p_recall;
    since_rst_r == 3'h3 && !mute_in |-> wiper_a_code == nv_a_code && wiper_b_code == nv_b_code;
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("wiper not zero under mute");
  a_mute_nv: assert property (p_mute_nv) else $error("stored code moved under mute");
  a_busy_hold: assert property (p_busy_hold) else $error("ready pulse too short");
  a_busy_len: assert property (p_busy_len) else $error("ready low time wrong");
  a_busy_nv: assert property (p_busy_nv) else $error("stored code moved while busy");
  a_release: assert property (p_release) else $error("data line not released");
  a_input_low: assert property (p_input_low) else $error("data line driven while selected");
  a_oe_start: assert property (p_oe_start) else $error("read drive started early");
  a_read_still: assert property (p_read_still) else $error("wiper moved during read");
  a_recall: assert property (p_recall) else $error("wipers not recalled");
endmodule
bind dual_pot_command_exec pot_checker #(.BUSY_CYCLES_P(BUSY_CYCLES_P)) chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .select_low_in(select_low_in), .mute_in(mute_in), .sdio_oe(sdio_oe),
  .ready_out(ready_out), .wiper_a_code(wiper_a_code), .wiper_b_code(wiper_b_code),
  .nv_a_code(nv_a_code), .nv_b_code(nv_b_code));

/* File: pot_host.sv */
// Host model of the three-wire link: command frames and read-back.
// Assumes the bench resolves the shared data line from the device enable.
`timescale 1ns/1ps
module pot_host (
  output logic sclk,
  output logic select_low,
  output logic data_drv,
  input wire logic sdio,
  input wire logic dev_oe
);
  // Link clock idles low, runs inside frames and during read-back with select high
  initial begin
    sclk = 1'b0;
    select_low = 1'b1;
    data_drv = 1'b0;
  end
  // Frame of n bits, MSB first, data set before each rise
  task xfer(input logic [15:0] w, input int n);
    select_low = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      data_drv = w[15-i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #40 select_low = 1'b1;
    data_drv = ~data_drv; // Last bit inverted, so no stale bit shows
  endtask
  // Read-back; a bit is taken at each clock fall from the third on
  task rd(output logic [7:0] b, output logic early, output logic rel);
    #40;
    early = 1'b0;
    for (int i = 0; i < 10; i++) begin
      sclk = 1'b1;
      #6 sclk = 1'b0;
      // Bit of the previous rise, taken past the device's sync delay
      if (i >= 2) b[9-i] = sdio;
      #6;
      if (i == 0) early = dev_oe;
      data_drv = ~data_drv;
    end
    #40 select_low = 1'b0;
    #30 rel = dev_oe;
    select_low = 1'b1;
  endtask
endmodule

/* File: tb.sv */
// Self-checking bench of the dual pot executor with a host link model.
// Assumes the executor's checker is bound in; stores shortened to 200 cycles.
`timescale 1ns/1ps
module tb;
  import pot_pkg::*;
  logic ref_clk, rst_n, mute_in, sclk, select_low, data_drv, sdo, soe, rdy;
  logic [7:0] wa, wb, na, nb, ea, eb, fa, fb;
  int failures, checks, seed, cyc;
  wire logic sdio_line = soe ? sdo : data_drv;
  dual_pot_command_exec #(.BUSY_CYCLES_P(200)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
    .select_low_in(select_low), .sdio_in(sdio_line), .sdio_out(sdo), .sdio_oe(soe), .mute_in(mute_in),
    .ready_out(rdy), .wiper_a_code(wa), .wiper_b_code(wb), .nv_a_code(na), .nv_b_code(nb));
  pot_host host (.sclk(sclk), .select_low(select_low), .data_drv(data_drv), .sdio(sdio_line), .dev_oe(soe));
  // 200 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      give_verdict;
    end
  end
  function automatic logic [7:0] pick(input logic s, input logic [7:0] a, input logic [7:0] b);
    return s ? b : a;
  endfunction
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task check_all;
    chk("wiper_a", wa, ea);
    chk("wiper_b", wb, eb);
    chk("nv_a", na, fa);
    chk("nv_b", nb, fb);
  endtask
  // One frame, then the expected codes follow the decode
  task run(input logic [7:0] c, input logic [7:0] d, input int n);
    logic bz, ok;
    logic [3:0] op;
    bz = (rdy === 1'b0);
    op = c[7:4];
    host.xfer({c, d}, n);
    repeat (10) @(negedge ref_clk);
    ok = c[3:2] == 2'b00 && c[1:0] != 2'b00 && (n == 8 || n == 16);
    if (ok && !mute_in && (op == OP_WR_WIPER && n == 16 || op == OP_CP_NV2W)) begin
      ea = pick(c[0], ea, op == OP_CP_NV2W ? fa : d);
      eb = pick(c[1], eb, op == OP_CP_NV2W ? fb : d);
    end
    if (ok && !bz && (op == OP_WR_NV && n == 16 || op == OP_CP_W2NV)) begin
      fa = pick(c[0], fa, op == OP_CP_W2NV ? ea : d);
      fb = pick(c[1], fb, op == OP_CP_W2NV ? eb : d);
    end
    check_all;
    #160;
  endtask
  task wait_ready;
    for (int k = 0; k < 400 && rdy !== 1'b1; k++) @(negedge ref_clk);
    chk("ready", {7'h00, rdy}, 8'h01);
  endtask
  task rdchk(input logic [7:0] c, input int n);
    logic [7:0] b;
    logic early, rel;
    host.xfer({c, 8'($random(seed))}, n);
    host.rd(b, early, rel);
    chk("read", b, c[7:4] == OP_RD_NV_DEF ? pick(c[1:0] == SEL_B, fa, fb) : pick(c[1:0] == SEL_B, ea, eb));
    chk("early", {7'h00, early}, 8'h00);
    chk("release", {7'h00, rel}, 8'h00);
    #200;
    check_all;
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    seed = 56101;
    rst_n = 1'b0;
    mute_in = 1'b0;
    {ea, eb, fa, fb} = {4{NV_RESET}};
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    check_all;
    $display("test power-up done");
    // Every write and copy code per channel; copies mix 8 and 16 bits
    for (int op = 0; op < 4; op++) begin
      for (int s = 1; s < 4; s++) begin
        run({op[3:0], 2'b00, s[1:0]}, 8'($random(seed)), (op > 1 && s != 2) ? 8 : 16);
        if (op == 1 || op == 2) chk("busy", {7'h00, rdy}, 8'h00);
        wait_ready;
      end
    end
    run(8'h03, 8'hFF, 16);
    run(8'h03, 8'h00, 16);
    $display("test codes done");
    // Wrong lengths, reserved bits, no channel, short write
    run(8'h03, 8'hA5, 15);
    run(8'h03, 8'hA5, 9);
    run(8'h33, 8'hA5, 7);
    run(8'h07, 8'hA5, 16);
    run(8'h00, 8'hA5, 16);
    run(8'h03, 8'hA5, 8);
    $display("test refusals done");
    run(8'h11, 8'h3C, 16);
    run(8'h12, 8'hC3, 16);
    wait_ready;
    $display("test busy done");
    for (int s = 1; s < 4; s++) begin
      rdchk({OP_RD_WIPER_DEF, 2'b00, s[1:0]}, 8);
      rdchk({OP_RD_NV_DEF, 2'b00, s[1:0]}, 16);
    end
    $display("test reads done");
    for (int i = 0; i < 24; i++) begin
      run({2'b00, 2'($random(seed)), 2'b00, 2'($random(seed))}, 8'($random(seed)),
          $random(seed) % 2 ? 8 : 16);
      wait_ready;
      rdchk({3'b010, 1'($random(seed)), 2'b00, 1'b1, 1'($random(seed))}, 8);
    end
    $display("test random done");
    @(negedge ref_clk) mute_in = 1'b1;
    repeat (8) @(negedge ref_clk);
    {ea, eb} = 16'h0000;
    check_all;
    run(8'h03, 8'h5A, 16);
    run(8'h33, 8'h00, 8);
    @(negedge ref_clk) mute_in = 1'b0;
    run(8'h03, 8'h96, 16);
    $display("test mute done");
    run(8'h23, 8'h00, 8);
    wait_ready;
    give_verdict;
  end
endmodule
